// ==== core/prsd_defs.svh ====
// Constants for the clock ratio strap decoder
`ifndef PRSD_DEFS_SVH
`define PRSD_DEFS_SVH

// Platform ratio strap codes
`define PRSD_PLAT_16 4'h0
`define PRSD_PLAT_3 4'h3
`define PRSD_PLAT_4 4'h4
`define PRSD_PLAT_5 4'h5
`define PRSD_PLAT_6 4'h6
`define PRSD_PLAT_8 4'h8
`define PRSD_PLAT_9 4'h9
`define PRSD_PLAT_10 4'hA
`define PRSD_PLAT_12 4'hC

// Platform code held under reset, a reserved code until straps are caught
`define PRSD_PLAT_RST 4'h1

// Core ratio strap codes (ratio given in halves)
`define PRSD_CORE_8H 3'h0
`define PRSD_CORE_9H 3'h1
`define PRSD_CORE_RSV 3'h2
`define PRSD_CORE_3H 3'h3
`define PRSD_CORE_4H 3'h4
`define PRSD_CORE_5H 3'h5
`define PRSD_CORE_6H 3'h6
`define PRSD_CORE_7H 3'h7

// Memory ratio strap codes
`define PRSD_MEM_3 3'h0
`define PRSD_MEM_4 3'h1
`define PRSD_MEM_6 3'h2
`define PRSD_MEM_8 3'h3
`define PRSD_MEM_10 3'h4
`define PRSD_MEM_12 3'h5
`define PRSD_MEM_RSV 3'h6
`define PRSD_MEM_SYNC 3'h7

// Supported reference clock and PCI clock ranges in kHz
`define PRSD_SYSREF_MIN_KHZ 32'd33330
`define PRSD_SYSREF_MAX_KHZ 32'd133330
`define PRSD_PCI_MIN_KHZ 32'd33000
`define PRSD_PCI_MAX_KHZ 32'd66000

`endif

// ==== core/prsd_pkg.sv ====
// Types for the clock ratio strap decoder
package prsd_pkg;
    typedef enum logic [1:0] {
        PRSD_IN_RESET = 2'b00,
        PRSD_LATCH = 2'b01,
        PRSD_HOLD = 2'b10
    } prsd_state_t;
endpackage

// ==== core/prsd_strap_decode.sv ====
// Power-up strap latch and clock ratio decoder
`timescale 1ns/1ps
`include "prsd_defs.svh"

module prsd_strap_decode #(
    parameter int FREQ_W = 32
) (
    input wire logic clock, // 20 MHz system clock
    input wire logic rst_b, // Power-up reset, active low
    input wire logic [3:0] platform_ratio_straps, // Platform ratio straps
    input wire logic core_ratio_strap_msb, // Core ratio strap bit 2
    input wire logic core_ratio_strap_mid, // Core ratio strap bit 1
    input wire logic core_ratio_strap_lsb, // Core ratio strap bit 0
    input wire logic [1:0] memory_ratio_strap_pins_hi, // Mem ratio bits 2:1
    input wire logic memory_ratio_strap_pin_lo, // Mem ratio bit 0
    input wire logic memory_clock_divide_setting, // Halve memory bus clock
    input wire logic [FREQ_W-1:0] sysref_khz, // System reference freq
    input wire logic [FREQ_W-1:0] memref_khz, // Memory reference freq
    output logic straps_valid, // Straps latched and decoded
    output logic [4:0] platform_ratio, // Platform:sysref multiple
    output logic platform_ratio_reserved, // Reserved platform code
    output logic [3:0] core_ratio_halves, // Core:platform ratio x2
    output logic core_ratio_reserved, // Reserved core code
    output logic [3:0] memory_ratio, // Data rate:memory reference
    output logic memory_ratio_reserved, // Reserved memory code
    output logic memory_sync_mode, // Memory runs synchronous
    output logic memory_ref_needed, // Memory reference clock used
    output logic pci_clock_from_async, // PCI clock taken from pin
    output logic sysref_in_range, // System reference supported
    output logic [FREQ_W-1:0] platform_khz, // Platform bus frequency
    output logic [FREQ_W-1:0] memory_data_khz, // Memory data rate
    output logic [FREQ_W-1:0] memory_bus_khz // Memory bus clock freq
);

    prsd_pkg::prsd_state_t state_q, state_d;
    logic [3:0] plat_code_q, plat_code_d;
    logic [2:0] core_code_q, core_code_d;
    logic [2:0] mem_code_q, mem_code_d;
    logic [4:0] plat_ratio_d, plat_ratio_q;
    logic plat_rsv_d, plat_rsv_q;
    logic [3:0] core_halves_d, core_halves_q;
    logic core_rsv_d, core_rsv_q;
    logic [3:0] mem_ratio_d, mem_ratio_q;
    logic mem_rsv_d, mem_rsv_q;
    logic sync_d, sync_q;
    logic [FREQ_W-1:0] plat_khz_d, plat_khz_q;
    logic [FREQ_W-1:0] data_khz_d, data_khz_q;
    logic [FREQ_W-1:0] bus_khz_d, bus_khz_q;
    logic pci_async_d, pci_async_q;
    logic range_d, range_q;

    // Straps are caught on the second edge after reset release, then frozen
    always_comb begin
        state_d = state_q;
        plat_code_d = plat_code_q;
        core_code_d = core_code_q;
        mem_code_d = mem_code_q;
        case (state_q)
            prsd_pkg::PRSD_IN_RESET: begin
                state_d = prsd_pkg::PRSD_LATCH;
            end
            prsd_pkg::PRSD_LATCH: begin
                plat_code_d = platform_ratio_straps;
                core_code_d = {core_ratio_strap_msb, core_ratio_strap_mid,
                               core_ratio_strap_lsb};
                mem_code_d = {memory_ratio_strap_pins_hi,
                              memory_ratio_strap_pin_lo};
                state_d = prsd_pkg::PRSD_HOLD;
            end
            prsd_pkg::PRSD_HOLD: begin
                state_d = prsd_pkg::PRSD_HOLD;
            end
            default: begin
                state_d = prsd_pkg::PRSD_IN_RESET;
            end
        endcase
    end

    // Strap registers take constants under reset, never the pins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= prsd_pkg::PRSD_IN_RESET;
            plat_code_q <= `PRSD_PLAT_RST;
            core_code_q <= `PRSD_CORE_RSV;
            mem_code_q <= `PRSD_MEM_RSV;
        end else begin
            state_q <= state_d;
            plat_code_q <= plat_code_d;
            core_code_q <= core_code_d;
            mem_code_q <= mem_code_d;
        end
    end

    // Decode the codes about to be held, so the ratio outputs come
    // from flops yet appear on the very edge that catches the straps
    always_comb begin
        // Platform ratio; unknown codes fall to the default, ratio zero, flagged reserved
        plat_rsv_d = 1'b0;
        case (plat_code_d)
            `PRSD_PLAT_16: plat_ratio_d = 5'h10;
            `PRSD_PLAT_3: plat_ratio_d = 5'h03;
            `PRSD_PLAT_4: plat_ratio_d = 5'h04;
            `PRSD_PLAT_5: plat_ratio_d = 5'h05;
            `PRSD_PLAT_6: plat_ratio_d = 5'h06;
            `PRSD_PLAT_8: plat_ratio_d = 5'h08;
            `PRSD_PLAT_9: plat_ratio_d = 5'h09;
            `PRSD_PLAT_10: plat_ratio_d = 5'h0A;
            `PRSD_PLAT_12: plat_ratio_d = 5'h0C;
            default: begin
                plat_ratio_d = 5'h00;
                plat_rsv_d = 1'b1;
            end
        endcase
        // Core ratio in halves to keep 9:2 exact
        core_rsv_d = 1'b0;
        case (core_code_d)
            `PRSD_CORE_8H: core_halves_d = 4'h8;
            `PRSD_CORE_9H: core_halves_d = 4'h9;
            `PRSD_CORE_3H: core_halves_d = 4'h3;
            `PRSD_CORE_4H: core_halves_d = 4'h4;
            `PRSD_CORE_5H: core_halves_d = 4'h5;
            `PRSD_CORE_6H: core_halves_d = 4'h6;
            `PRSD_CORE_7H: core_halves_d = 4'h7;
            default: begin
                core_halves_d = 4'h0;
                core_rsv_d = 1'b1;
            end
        endcase
        // Memory ratio; sync and reserved carry ratio zero
        mem_rsv_d = 1'b0;
        sync_d = 1'b0;
        case (mem_code_d)
            `PRSD_MEM_3: mem_ratio_d = 4'h3;
            `PRSD_MEM_4: mem_ratio_d = 4'h4;
            `PRSD_MEM_6: mem_ratio_d = 4'h6;
            `PRSD_MEM_8: mem_ratio_d = 4'h8;
            `PRSD_MEM_10: mem_ratio_d = 4'hA;
            `PRSD_MEM_12: mem_ratio_d = 4'hC;
            `PRSD_MEM_SYNC: begin
                mem_ratio_d = 4'h0;
                sync_d = 1'b1;
            end
            default: begin
                mem_ratio_d = 4'h0;
                mem_rsv_d = 1'b1;
            end
        endcase
    end

    // Decoded ratio registers; reset values match the reset codes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            plat_ratio_q <= 5'h00;
            plat_rsv_q <= 1'b1;
            core_halves_q <= 4'h0;
            core_rsv_q <= 1'b1;
            mem_ratio_q <= 4'h0;
            mem_rsv_q <= 1'b1;
            sync_q <= 1'b0;
        end else begin
            plat_ratio_q <= plat_ratio_d;
            plat_rsv_q <= plat_rsv_d;
            core_halves_q <= core_halves_d;
            core_rsv_q <= core_rsv_d;
            mem_ratio_q <= mem_ratio_d;
            mem_rsv_q <= mem_rsv_d;
            sync_q <= sync_d;
        end
    end

    // Frequency arithmetic; registered so data outputs come from flops
    always_comb begin
        range_d = (sysref_khz >= FREQ_W'(`PRSD_SYSREF_MIN_KHZ)) &&
                  (sysref_khz <= FREQ_W'(`PRSD_SYSREF_MAX_KHZ));
        plat_khz_d = FREQ_W'(sysref_khz * plat_ratio_q);
        if (sync_q) begin
            // Memory reference is not looked at in this mode
            data_khz_d = plat_khz_d;
        end else begin
            data_khz_d = FREQ_W'(memref_khz * mem_ratio_q);
        end
        bus_khz_d = data_khz_d >> 1;
        if (memory_clock_divide_setting) begin
            // Software must settle this before memory init
            bus_khz_d = data_khz_d >> 2;
        end
        // A system reference outside the PCI clock range forces the separate PCI pin
        pci_async_d = (sysref_khz < FREQ_W'(`PRSD_PCI_MIN_KHZ)) ||
                      (sysref_khz > FREQ_W'(`PRSD_PCI_MAX_KHZ));
    end

    // Frequency result registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            plat_khz_q <= '0;
            data_khz_q <= '0;
            bus_khz_q <= '0;
            pci_async_q <= 1'b0;
            range_q <= 1'b0;
        end else begin
            plat_khz_q <= plat_khz_d;
            data_khz_q <= data_khz_d;
            bus_khz_q <= bus_khz_d;
            pci_async_q <= pci_async_d;
            range_q <= range_d;
        end
    end

    // Decoded values are stable flop outputs once latched
    assign straps_valid = (state_q == prsd_pkg::PRSD_HOLD);
    assign platform_ratio = plat_ratio_q;
    assign platform_ratio_reserved = plat_rsv_q;
    assign core_ratio_halves = core_halves_q;
    assign core_ratio_reserved = core_rsv_q;
    assign memory_ratio = mem_ratio_q;
    assign memory_ratio_reserved = mem_rsv_q;
    assign memory_sync_mode = sync_q;
    assign memory_ref_needed = !sync_q;
    assign pci_clock_from_async = pci_async_q;
    assign sysref_in_range = range_q;
    assign platform_khz = plat_khz_q;
    assign memory_data_khz = data_khz_q;
    assign memory_bus_khz = bus_khz_q;

endmodule

// ==== verification/prsd_strap_checker.sv ====
// Checker for the clock ratio strap decoder
`timescale 1ns/1ps
module prsd_strap_checker #(
    parameter int FREQ_W = 32 // Frequency word width, as the design
) (
    input wire logic clock, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic core_ratio_strap_msb, // Core bit 2
    input wire logic core_ratio_strap_mid, // Core bit 1
    input wire logic core_ratio_strap_lsb, // Core bit 0
    input wire logic [1:0] memory_ratio_strap_pins_hi, // Mem bits 2:1
    input wire logic memory_ratio_strap_pin_lo, // Mem bit 0
    input wire logic memory_clock_divide_setting, // Divide
    input wire logic [FREQ_W-1:0] sysref_khz, // Reference freq
    input wire logic [FREQ_W-1:0] memref_khz, // Memory reference freq
    input wire logic straps_valid, // Latched
    input wire logic [4:0] platform_ratio, // Platform ratio
    input wire logic [3:0] core_ratio_halves, // Core ratio
    input wire logic core_ratio_reserved, // Core reserved
    input wire logic [3:0] memory_ratio, // Memory ratio
    input wire logic memory_sync_mode, // Sync mode
    input wire logic memory_ref_needed, // Mem ref used
    input wire logic pci_clock_from_async, // PCI from pin
    input wire logic [FREQ_W-1:0] platform_khz, // Platform freq
    input wire logic [FREQ_W-1:0] memory_data_khz, // Data rate
    input wire logic [FREQ_W-1:0] memory_bus_khz // Bus clock
);
    logic v_q;
    wire steady = straps_valid && v_q;
    // Frequencies lag the latch by one edge, so wait one more
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) v_q <= 1'b0;
        else v_q <= straps_valid;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_ratio_hold: assert property (steady |-> $stable(platform_ratio) &&
        $stable(core_ratio_halves) && $stable(memory_ratio))
        else $error("ratio moved after latch");
    a_mem_sync_code: assert property ($rose(straps_valid) |->
        memory_sync_mode == ($past({memory_ratio_strap_pins_hi,
        memory_ratio_strap_pin_lo}) == 3'h7)) else $error("sync decode");
    a_core_rsv_code: assert property ($rose(straps_valid) |->
        core_ratio_reserved == ($past({core_ratio_strap_msb,
        core_ratio_strap_mid, core_ratio_strap_lsb}) == 3'h2))
        else $error("core reserved decode");
    a_sync_no_ref: assert property (memory_sync_mode |->
        memory_ratio == 4'h0 && !memory_ref_needed) else $error("sync ref");
    a_plat_freq: assert property (steady |->
        platform_khz == $past(sysref_khz) * platform_ratio)
        else $error("platform freq");
    a_sync_data: assert property (steady && memory_sync_mode |->
        memory_data_khz == platform_khz) else $error("sync data rate");
    a_async_data: assert property (steady && !memory_sync_mode |->
        memory_data_khz == $past(memref_khz) * memory_ratio)
        else $error("async data rate");
    a_bus_half: assert property (steady |-> memory_bus_khz ==
        ($past(memory_clock_divide_setting) ? memory_data_khz >> 2 :
        memory_data_khz >> 1)) else $error("bus clock");
    a_pci_source: assert property (steady |-> pci_clock_from_async ==
        ($past(sysref_khz) < 32'd33000 || $past(sysref_khz) > 32'd66000))
        else $error("pci source");
    c_sync: cover property (steady && memory_sync_mode);
    c_div: cover property (steady && memory_clock_divide_setting);
    c_pci: cover property (steady && pci_clock_from_async);
endmodule
bind prsd_strap_decode prsd_strap_checker #(.FREQ_W(FREQ_W))
    i_prsd_strap_checker (.clock,
    .rst_b, .core_ratio_strap_msb, .core_ratio_strap_mid,
    .core_ratio_strap_lsb, .memory_ratio_strap_pins_hi,
    .memory_ratio_strap_pin_lo, .memory_clock_divide_setting, .sysref_khz,
    .memref_khz, .straps_valid, .platform_ratio, .core_ratio_halves,
    .core_ratio_reserved, .memory_ratio, .memory_sync_mode,
    .memory_ref_needed, .pci_clock_from_async, .platform_khz,
    .memory_data_khz, .memory_bus_khz);

// ==== verification/prsd_board_model.sv ====
// Board strap resistors: fixed levels, later pin activity on demand
`timescale 1ns/1ps
module prsd_board_model (
    input wire logic [3:0] plat_code, // Platform strap level
    input wire logic [2:0] core_code, // Core strap level
    input wire logic [2:0] mem_code, // Memory strap level
    input wire logic wiggle, // Reuse pins after power-up
    output logic [3:0] plat_pins, // Platform strap pins
    output logic [2:0] core_pins, // Core strap pins
    output logic [2:0] mem_pins // Memory strap pins
);
    // Every bit pulled to a level; reuse flips them all
    always_comb begin
        plat_pins = wiggle ? ~plat_code : plat_code;
        core_pins = wiggle ? ~core_code : core_code;
        mem_pins = wiggle ? ~mem_code : mem_code;
    end
endmodule

// ==== verification/pll_ratio_strap_decode_tb_top.sv ====
// Testbench for the clock ratio strap decoder
`timescale 1ns/1ps
module pll_ratio_strap_decode_tb_top;
    logic clock = 1'b0, rst_b = 1'b0, wiggle = 1'b0, div = 1'b0;
    logic [3:0] pc = 4'h4, plat_pins;
    logic [2:0] cc = 3'h0, mc = 3'h0, core_pins, mem_pins;
    logic [31:0] sysref = 32'd100000, memref = 32'd50000;
    logic [31:0] pk, dk, bk;
    logic [4:0] pr;
    logic [3:0] ch, mr;
    logic v, prs, crs, mrs, sm, rn, pci, rng;
    int fail_count = 0, comparisons = 0;
    int plat_x[16] = '{16, 0, 0, 3, 4, 5, 6, 0, 8, 9, 10, 0, 12, 0, 0, 0};
    int core_x[8] = '{8, 9, 0, 3, 4, 5, 6, 7};
    int mem_x[8] = '{3, 4, 6, 8, 10, 12, 0, 0};
    always #25 clock = ~clock;
    prsd_board_model i_prsd_board_model (.plat_code(pc), .core_code(cc),
        .mem_code(mc), .wiggle(wiggle), .plat_pins(plat_pins),
        .core_pins(core_pins), .mem_pins(mem_pins));
    prsd_strap_decode i_prsd_strap_decode (.clock(clock), .rst_b(rst_b),
        .platform_ratio_straps(plat_pins), .core_ratio_strap_msb(core_pins[2]),
        .core_ratio_strap_mid(core_pins[1]), .core_ratio_strap_lsb(core_pins[0]),
        .memory_ratio_strap_pins_hi(mem_pins[2:1]),
        .memory_ratio_strap_pin_lo(mem_pins[0]),
        .memory_clock_divide_setting(div), .sysref_khz(sysref),
        .memref_khz(memref), .straps_valid(v), .platform_ratio(pr),
        .platform_ratio_reserved(prs), .core_ratio_halves(ch),
        .core_ratio_reserved(crs), .memory_ratio(mr),
        .memory_ratio_reserved(mrs), .memory_sync_mode(sm),
        .memory_ref_needed(rn), .pci_clock_from_async(pci),
        .sysref_in_range(rng), .platform_khz(pk), .memory_data_khz(dk),
        .memory_bus_khz(bk));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Power-up with given straps, then reuse the pins to prove the hold
    task power_up(input logic [3:0] p, input logic [2:0] c, m);
        @(negedge clock);
        rst_b = 1'b0;
        wiggle = 1'b0;
        {pc, cc, mc} = {p, c, m};
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        wiggle = 1'b1;
        @(negedge clock);
        chk(v, 1'b1);
    endtask
    task t_plat();
        for (int i = 0; i < 16; i++) begin
            power_up(i[3:0], 3'h0, 3'h0);
            chk(pr, plat_x[i]);
            chk(prs, plat_x[i] == 0);
            chk(pk, sysref * plat_x[i]);
        end
    endtask
    task t_core();
        for (int i = 0; i < 8; i++) begin
            power_up(4'h4, i[2:0], 3'h0);
            chk(ch, core_x[i]);
            chk(crs, i == 2);
        end
    endtask
    // Every memory code, each with and without the divide setting
    task t_mem();
        logic [31:0] data_x;
        for (int i = 0; i < 8; i++) begin
            div = 1'b0;
            power_up(4'h4, 3'h0, i[2:0]);
            // Sync follows the platform rate: reference times ratio 4
            data_x = (i == 7) ? sysref * 4 : memref * mem_x[i];
            chk(mr, mem_x[i]);
            chk({mrs, sm, rn}, {i == 6, i == 7, i != 7});
            chk(dk, data_x);
            chk(bk, data_x >> 1);
            div = 1'b1; // Set before any memory controller start
            repeat (2) @(negedge clock);
            chk(bk, data_x >> 2);
        end
        div = 1'b0;
    endtask
    // Reference clock on both sides of each PCI range edge, and just above the system reference maximum
    task t_pci();
        logic [31:0] f[5] = '{32999, 33000, 66000, 66001, 133331};
        power_up(4'h4, 3'h0, 3'h0);
        for (int i = 0; i < 5; i++) begin
            sysref = f[i]; // Board adds a PCI clock when out of range
            repeat (2) @(negedge clock);
            chk(pci, i == 0 || i > 2);
            chk(rng, i == 2 || i == 3);
        end
    endtask
    task finish_test();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        t_plat();
        t_core();
        t_mem();
        t_pci();
        finish_test();
    end
    // Whole run is near 356 cycles; this is about fourteen times that
    initial begin
        #250000;
        fail_count++;
        finish_test();
    end
endmodule
